/* File: msd_slot_demux_regs.vh */
// register offsets, entry fields and reset values of the subchannel slot demux
`ifndef MSD_SLOT_DEMUX_REGS_VH
`define MSD_SLOT_DEMUX_REGS_VH

// ----------------------------------------
// register word addresses
// ----------------------------------------
`define MSD_RX_TABLE_BASE  7'h00
`define MSD_TX_TABLE_BASE  7'h20
`define MSD_MODE_ADDR      7'h40
`define MSD_STATUS_ADDR    7'h41
`define MSD_TABLE_SEL_MSB  6
`define MSD_TABLE_SEL_LSB  5
`define MSD_SEL_RX         2'h0
`define MSD_SEL_TX         2'h1

// ----------------------------------------
// slot table entry fields
// ----------------------------------------
`define MSD_ENTRY_VALID    15
`define MSD_ENTRY_WRAP     14
`define MSD_MASK_HI_MSB    13
`define MSD_MASK_HI_LSB    12
`define MSD_ENTRY_LAST     11
`define MSD_CHAN_MSB       10
`define MSD_CHAN_LSB       6
`define MSD_MASK_LO_MSB    5
`define MSD_MASK_LO_LSB    0
`define MSD_PARAM_LOW_ZERO 6'h00

// ----------------------------------------
// reset values
// ----------------------------------------
`define MSD_ENTRY_RST      16'h0000
`define MSD_MODE_RST       32'h00000000
`define MSD_IDLE_BYTE      8'hff
`define MSD_FIRST_BIT_POS  3'h7
`define MSD_LAST_BIT_POS   3'h7

`endif

/* File: msd_slot_walker.v */
// walks slot table entries for one 8-bit slot, one bit position per cycle
`timescale 1ns/1ps
`default_nettype none
`include "msd_slot_demux_regs.vh"

module msd_slot_walker #(
  parameter IDXW = 5
) (
  // clock, reset, enable
  input  wire            ref_clk,
  input  wire            reset,
  input  wire            clkEn,
  // slot timing
  input  wire            frameStart,
  input  wire            slotStart,
  input  wire [7:0]      slotByte,
  // table access
  output wire [IDXW-1:0] entryIdx,
  input  wire [15:0]     entry,
  // bit stream to and from the serial controller
  output wire            bitStrobe,
  output wire            bitValue,
  input  wire            bitIn,
  output wire [7:0]      outByte,
  output wire            busy
);

  reg [IDXW-1:0] ptrReg;
  reg [2:0]      posReg;
  reg            runReg;
  reg [7:0]      byteReg;

  wire [7:0] mask = {entry[`MSD_MASK_HI_MSB:`MSD_MASK_HI_LSB],
                     entry[`MSD_MASK_LO_MSB:`MSD_MASK_LO_LSB]};

  // only valid entries with a set mask bit touch the channel; others skip silently
  wire take = runReg & entry[`MSD_ENTRY_VALID] & mask[posReg];

  assign entryIdx  = ptrReg;
  assign bitStrobe = take;
  assign bitValue  = byteReg[posReg];
  assign outByte   = byteReg;
  assign busy      = runReg;

  // ----------------------------------------
  // entry sequencing
  // ----------------------------------------
  // one cycle per bit position keeps the walk far shorter than a link slot
  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      ptrReg  <= {IDXW{1'b0}};
      posReg  <= `MSD_FIRST_BIT_POS;
      runReg  <= 1'b0;
      byteReg <= `MSD_IDLE_BYTE;
    end
    else if (clkEn)
    begin
      if (frameStart)
      begin
        ptrReg <= {IDXW{1'b0}};         // frame sync restarts at entry 0
        runReg <= 1'b0;
      end
      else if (!runReg && slotStart)
      begin
        byteReg <= slotByte;
        posReg  <= `MSD_FIRST_BIT_POS;
        runReg  <= 1'b1;
      end
      else if (runReg)
      begin
        if (take)
          byteReg[posReg] <= bitIn;
        if (posReg == 3'h0)
        begin
          // every entry of a slot sees the same byte, in table order
          ptrReg <= entry[`MSD_ENTRY_WRAP] ? {IDXW{1'b0}} : ptrReg + 1'b1;
          posReg <= `MSD_FIRST_BIT_POS;
          if (entry[`MSD_ENTRY_LAST])
            runReg <= 1'b0;
        end
        else
          posReg <= posReg - 3'h1;
      end
    end
  end

endmodule
`default_nettype wire

/* File: msd_slot_demux.v */
// subchannel slot demultiplexer: link framing, slot tables, controller port
`timescale 1ns/1ps
`default_nettype none
`include "msd_slot_demux_regs.vh"

module msd_slot_demux #(
  parameter NCHAN = 32,
  parameter IDXW  = 5
) (
  // clock, reset, enable
  input  wire        ref_clk,
  input  wire        reset,
  input  wire        clkEn,
  // register port
  input  wire [6:0]  regAddr,
  input  wire [31:0] regWdata,
  input  wire        regWr,
  input  wire        regRd,
  output reg  [31:0] regRdata,
  // link pins
  input  wire        linkBitClk,
  input  wire        linkFrameSync,
  input  wire        linkRxData,
  output reg         linkTxData,
  // receive side of the serial controller
  output reg         rxBitStrobe,
  output reg         rxBit,
  output reg  [4:0]  rxChan,
  output wire [10:0] rxParamAddr,
  output reg         rxHdlc,
  // transmit side of the serial controller
  output wire        txBitReq,
  output wire [4:0]  txChan,
  output wire [10:0] txParamAddr,
  output wire        txHdlc,
  input  wire        txBitIn
);

  // ----------------------------------------
  // configuration storage
  // ----------------------------------------
  reg [15:0]      rxTable [0:NCHAN-1];
  reg [15:0]      txTable [0:NCHAN-1];
  reg [NCHAN-1:0] modeReg;   // 1 = HDLC, 0 = transparent

  wire [IDXW-1:0] rxIdx;
  wire [IDXW-1:0] txIdx;
  wire            rxBusy;
  wire            txBusy;
  wire [15:0]     rxEntry = rxTable[rxIdx];
  wire [15:0]     txEntry = txTable[txIdx];

  integer i;

  // table and mode writes; reads answer one cycle later
  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      for (i = 0; i < NCHAN; i = i + 1)
      begin
        rxTable[i] <= `MSD_ENTRY_RST;
        txTable[i] <= `MSD_ENTRY_RST;
      end
      modeReg  <= `MSD_MODE_RST;
      regRdata <= 32'h00000000;
    end
    else if (clkEn)
    begin
      if (regWr)
      begin
        if (regAddr[`MSD_TABLE_SEL_MSB:`MSD_TABLE_SEL_LSB] == `MSD_SEL_RX)
          rxTable[regAddr[IDXW-1:0]] <= regWdata[15:0];
        else if (regAddr[`MSD_TABLE_SEL_MSB:`MSD_TABLE_SEL_LSB] == `MSD_SEL_TX)
          txTable[regAddr[IDXW-1:0]] <= regWdata[15:0];
        else if (regAddr == `MSD_MODE_ADDR)
          modeReg <= regWdata[NCHAN-1:0];
      end
      regRdata <= 32'h00000000;
      if (regRd)
      begin
        if (regAddr[`MSD_TABLE_SEL_MSB:`MSD_TABLE_SEL_LSB] == `MSD_SEL_RX)
          regRdata <= {16'h0000, rxTable[regAddr[IDXW-1:0]]};
        else if (regAddr[`MSD_TABLE_SEL_MSB:`MSD_TABLE_SEL_LSB] == `MSD_SEL_TX)
          regRdata <= {16'h0000, txTable[regAddr[IDXW-1:0]]};
        else if (regAddr == `MSD_MODE_ADDR)
          regRdata <= modeReg;
        else if (regAddr == `MSD_STATUS_ADDR)
          regRdata <= {17'h00000, txIdx, 3'h0, rxIdx, rxBusy, txBusy};
      end
    end
  end

  // ----------------------------------------
  // link pin synchronisers
  // ----------------------------------------
  reg [2:0] bitClkSync;
  reg [2:0] fsSync;
  reg [1:0] rxSync;

  // third stage only feeds edge detection, never the first stage
  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      bitClkSync <= 3'h0;
      fsSync     <= 3'h0;
      rxSync     <= 2'h0;
    end
    else if (clkEn)
    begin
      bitClkSync <= {bitClkSync[1:0], linkBitClk};
      fsSync     <= {fsSync[1:0], linkFrameSync};
      rxSync     <= {rxSync[0], linkRxData};
    end
  end

  wire bitEdge = bitClkSync[1] & ~bitClkSync[2];
  wire fsRise  = fsSync[1] & ~fsSync[2];
  wire rxIn    = rxSync[1];

  // ----------------------------------------
  // slot framing
  // ----------------------------------------
  reg [2:0] bitCnt;
  reg [6:0] rxShift;
  reg [7:0] rxSlotByte;
  reg       rxSlotStart;
  reg [7:0] txShift;
  reg       txSlotStart;
  wire [7:0] txNextByte;

  // transmit runs one slot behind: byte n+1 is built while byte n shifts out
  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      bitCnt      <= 3'h0;
      rxShift     <= 7'h00;
      rxSlotByte  <= `MSD_IDLE_BYTE;
      rxSlotStart <= 1'b0;
      txShift     <= `MSD_IDLE_BYTE;
      txSlotStart <= 1'b0;
      linkTxData  <= 1'b1;
    end
    else if (clkEn)
    begin
      rxSlotStart <= 1'b0;
      txSlotStart <= 1'b0;
      if (fsRise)
        bitCnt <= 3'h0;
      else if (bitEdge)
      begin
        bitCnt  <= bitCnt + 3'h1;
        rxShift <= {rxShift[5:0], rxIn};
        if (bitCnt == `MSD_LAST_BIT_POS)
        begin
          rxSlotByte  <= {rxShift, rxIn}; // whole slot to one engine
          rxSlotStart <= 1'b1;
        end
        if (bitCnt == 3'h0)
        begin
          linkTxData  <= txNextByte[7];
          txShift     <= {txNextByte[6:0], 1'b1};
          txSlotStart <= 1'b1;
        end
        else
        begin
          linkTxData <= txShift[7];
          txShift    <= {txShift[6:0], 1'b1};
        end
      end
    end
  end

  // ----------------------------------------
  // receive and transmit table walkers
  // ----------------------------------------
  wire rxTake;
  wire rxValue;

  msd_slot_walker #(.IDXW(IDXW)) rxWalker (
    .ref_clk    (ref_clk),
    .reset      (reset),
    .clkEn      (clkEn),
    .frameStart (fsRise),
    .slotStart  (rxSlotStart),
    .slotByte   (rxSlotByte),
    .entryIdx   (rxIdx),
    .entry      (rxEntry),
    .bitStrobe  (rxTake),
    .bitValue   (rxValue),
    .bitIn      (rxValue),
    .outByte    (),
    .busy       (rxBusy)
  );

  // invalid transmit entries leave the idle ones in place
  msd_slot_walker #(.IDXW(IDXW)) txWalker (
    .ref_clk    (ref_clk),
    .reset      (reset),
    .clkEn      (clkEn),
    .frameStart (fsRise),
    .slotStart  (txSlotStart),
    .slotByte   (`MSD_IDLE_BYTE),
    .entryIdx   (txIdx),
    .entry      (txEntry),
    .bitStrobe  (txBitReq),
    .bitValue   (),
    .bitIn      (txBitIn),
    .outByte    (txNextByte),
    .busy       (txBusy)
  );

  // ----------------------------------------
  // serial controller outputs
  // ----------------------------------------
  wire [4:0] rxSel = rxEntry[`MSD_CHAN_MSB:`MSD_CHAN_LSB];

  // receive bits registered so data leaves from flip-flops
  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      rxBitStrobe <= 1'b0;
      rxBit       <= 1'b0;
      rxChan      <= 5'h00;
      rxHdlc      <= 1'b0;
    end
    else if (clkEn)
    begin
      rxBitStrobe <= rxTake;
      if (rxTake)
      begin
        rxBit  <= rxValue;
        rxChan <= rxSel;
        rxHdlc <= modeReg[rxSel];
      end
    end
  end

  // transmit request is a same-cycle handshake; txBitIn answers it
  assign txChan      = txEntry[`MSD_CHAN_MSB:`MSD_CHAN_LSB];
  assign txHdlc      = modeReg[txChan];
  assign rxParamAddr = {rxChan, `MSD_PARAM_LOW_ZERO};
  assign txParamAddr = {txChan, `MSD_PARAM_LOW_ZERO};

endmodule
`default_nettype wire

/* File: msd_demux_props.sv */
// port checker for the subchannel slot demux
`timescale 1ns/1ps
`default_nettype none
module msd_demux_props (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        reset,
  // register port
  input wire logic [6:0]  regAddr,
  input wire logic [31:0] regWdata,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [31:0] regRdata,
  // controller side
  input wire logic        rxBitStrobe,
  input wire logic        rxBit,
  input wire logic [4:0]  rxChan,
  input wire logic [10:0] rxParamAddr,
  input wire logic        rxHdlc,
  input wire logic        txBitReq,
  input wire logic [4:0]  txChan,
  input wire logic [10:0] txParamAddr,
  input wire logic        txHdlc
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // mode shadow, so a delivered bit can be tied to its channel mode
  logic [31:0] modeReg;
  always @(posedge ref_clk)
    if (reset) modeReg <= 32'h0;
    else if (regWr && regAddr == 7'h40) modeReg <= regWdata;
  property p_rxPar; rxBitStrobe |-> rxParamAddr == {rxChan, 6'h00}; endproperty
  a_rxPar: assert property (p_rxPar) else $error("rx param address");
  property p_txPar; txBitReq |-> txParamAddr == {txChan, 6'h00}; endproperty
  a_txPar: assert property (p_txPar) else $error("tx param address");
  property p_rdIdle; !regRd |=> regRdata == 32'h0; endproperty
  a_rdIdle: assert property (p_rdIdle) else $error("read data outside slot");
  // outputs hold between strobes; a reset edge is allowed to clear them
  property p_hold; !rxBitStrobe && !$past(reset) |-> $stable(rxChan) && $stable(rxBit); endproperty
  a_hold: assert property (p_hold) else $error("rx outputs moved");
  property p_entry;
    regWr && regAddr < 7'h40 ##1 regRd && regAddr == $past(regAddr)
      |=> regRdata == ($past(regWdata, 2) & 32'h0000ffff);
  endproperty
  a_entry: assert property (p_entry) else $error("entry readback");
  property p_unmap; regRd && regAddr > 7'h41 |=> regRdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_rxMode; rxBitStrobe |-> rxHdlc == modeReg[rxChan]; endproperty
  a_rxMode: assert property (p_rxMode) else $error("rx mode");
  property p_txMode; txBitReq |-> txHdlc == modeReg[txChan]; endproperty
  a_txMode: assert property (p_txMode) else $error("tx mode");
endmodule
bind msd_slot_demux msd_demux_props i_props (.ref_clk, .reset, .regAddr, .regWdata, .regWr,
  .regRd, .regRdata, .rxBitStrobe, .rxBit, .rxChan, .rxParamAddr, .rxHdlc, .txBitReq,
  .txChan, .txParamAddr, .txHdlc);
`default_nettype wire

/* File: msd_link_model.sv */
// far end of the serial link: frame sync, bit clock, data both ways
`timescale 1ns/1ps
`default_nettype none
module msd_link_model (
  // pacing clock
  input wire logic  ref_clk,
  // link pins
  output logic       linkBitClk,
  output logic       linkFrameSync,
  output logic       linkRxData,
  input wire logic  linkTxData,
  // last eight bits heard on transmit
  output logic [7:0] txCap
);
  // bit clock stands still outside frames
  initial
  begin
    linkBitClk = 1'b0;
    linkFrameSync = 1'b0;
    linkRxData = 1'b0;
    txCap = 8'h00;
  end
  task automatic waitc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // sync pulse well ahead of the first bit edge
  task automatic frame();
    linkFrameSync <= 1'b1;
    waitc(4);
    linkFrameSync <= 1'b0;
    waitc(4);
  endtask
  // one slot, bit 7 first; tx sampled late in the bit, after the sync delay
  task automatic slot(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      linkRxData <= b[i];
      waitc(8);
      linkBitClk <= 1'b1;
      waitc(8);
      txCap <= {txCap[6:0], linkTxData};
      linkBitClk <= 1'b0;
    end
    linkRxData <= ~b[0]; // released line shows no stale level
    waitc(48);
  endtask
endmodule
`default_nettype wire

/* File: msd_tb.sv */
// self-checking bench for the subchannel slot demux
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, ac) \
  begin check_count++; if ((ac) !== (ex)) begin n_errors++; \
  $display("Error %s expected %h seen %h", nm, ex, ac); end end
module testbench;
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic [6:0]  regAddr = 7'h00;
  logic [31:0] regWdata = 32'h0;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic [7:0]  txCnt = 8'h00;
  logic [6:0]  got[$];
  logic [7:0]  txCap;
  wire [31:0]  regRdata;
  wire         linkBitClk, linkFrameSync, linkRxData, linkTxData;
  wire         rxBitStrobe, rxBit, rxHdlc, txBitReq, txHdlc;
  wire [4:0]   rxChan, txChan;
  int          n_errors = 0;
  int          check_count = 0;
  always #20 ref_clk = ~ref_clk;
  // controller stand-in: alternating bits, counted per request
  always @(posedge ref_clk) if (txBitReq) txCnt <= txCnt + 8'h01;
  always @(posedge ref_clk) if (rxBitStrobe) got.push_back({rxHdlc, rxChan, rxBit});
  msd_slot_demux i_dut (.ref_clk(ref_clk), .reset(reset), .clkEn(1'b1), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .linkBitClk(linkBitClk), .linkFrameSync(linkFrameSync), .linkRxData(linkRxData),
    .linkTxData(linkTxData), .rxBitStrobe(rxBitStrobe), .rxBit(rxBit), .rxChan(rxChan),
    .rxParamAddr(), .rxHdlc(rxHdlc), .txBitReq(txBitReq), .txChan(txChan),
    .txParamAddr(), .txHdlc(txHdlc), .txBitIn(txCnt[0]));
  msd_link_model i_link (.ref_clk(ref_clk), .linkBitClk(linkBitClk),
    .linkFrameSync(linkFrameSync), .linkRxData(linkRxData), .linkTxData(linkTxData),
    .txCap(txCap));
  function automatic logic [15:0] ent(input logic v, w, l, input logic [4:0] c,
                                      input logic [7:0] m);
    return {v, w, m[7:6], l, c, m[5:0]};
  endfunction
  // write waits an edge first, so a read may follow with no gap
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, output logic [31:0] d);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    @(posedge ref_clk);
    d = regRdata;
  endtask
  task automatic t_regs();
    logic [31:0] d;
    wr(7'h1f, 32'hffff_a5c3);
    rd(7'h1f, d);
    `CHK("entry", 32'h0000_a5c3, d)
    rd(7'h7f, d);
    `CHK("unmapped", 32'h0, d)
  endtask
  task automatic t_tx();
    int c0;
    wr(7'h20, {16'h0, ent(1'b1, 1'b1, 1'b1, 5'd3, 8'h0f)});
    i_link.frame();
    c0 = txCnt;
    i_link.slot(8'h00);
    `CHK("tx first", 8'hff, txCap)
    `CHK("tx requests", 4, txCnt - c0)
    i_link.slot(8'h00);
    `CHK("tx byte", c0 % 2 ? 8'hfa : 8'hf5, txCap)
  endtask
  // four 2-bit subchannels, an invalid slot, then a sparse wrapping slot
  task automatic t_rx();
    logic [4:0] ch[4] = '{5'd5, 5'd9, 5'd17, 5'd31};
    logic [7:0] m[4] = '{8'hc0, 8'h30, 8'h0c, 8'h03};
    logic [7:0] b = 8'hb4;
    wr(7'h40, 32'h0000_0200);
    for (int i = 0; i < 4; i++) wr(7'(i), {16'h0, ent(1'b1, 1'b0, i == 3, ch[i], m[i])});
    wr(7'h04, {16'h0, ent(1'b0, 1'b0, 1'b1, 5'd2, 8'hff)});
    wr(7'h05, {16'h0, ent(1'b1, 1'b1, 1'b1, 5'd6, 8'h81)});
    i_link.frame();
    got.delete();
    i_link.slot(b);
    i_link.slot(8'hff);
    i_link.slot(8'h81);
    `CHK("rx count", 10, got.size())
    for (int i = 0; i < 8; i++) `CHK("rx bit", {ch[i/2] == 5'd9, ch[i/2], b[7-i]}, got[i])
    `CHK("rx sparse hi", 7'h0d, got[8])
    `CHK("rx sparse lo", 7'h0d, got[9])
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // a run needs under a thousand cycles; this bound only catches hangs
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    $display("Error watchdog expected done seen timeout");
    end_of_test();
  end
  initial
  begin
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    t_regs();
    t_tx();
    t_rx();
    end_of_test();
  end
endmodule
`default_nettype wire
